// [kli_detect.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Level comparator, one per line
// ----------------------------------------
module kli_detect
  import kli_pkg::*;
(
  kli_det_if.det det // Sync lines in, hits out
);
  genvar g;
  // Match each line against its selected level
  generate
    for (g = 0; g < KLI_LINES; g++) begin : g_line
      assign det.hit[g] = (det.line_sync[g] == det.level_sel[g]);
    end
  endgenerate
endmodule

// [kli_if.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Per-line detection carrier
// ----------------------------------------
interface kli_det_if;
  logic [7:0] line_sync;
  logic [7:0] level_sel;
  logic [7:0] hit;
  modport det (input line_sync, input level_sel, output hit);
  modport ctl (output line_sync, output level_sel, input hit);
endinterface

// [kli_keypad_model.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Keypad lines on the port pins
// ----------------------------------------
module kli_keypad_model (
  input wire logic clock, // Bench clock
  input wire logic [7:0] press, // Wanted line levels
  output logic [7:0] lines // Port lines
);
  // Pulled up at rest
  initial lines = 8'hFF;
  // Held levels, moved shortly after the edge
  always @(posedge clock) begin
    lines <= #2 press;
  end
endmodule

// [kli_pkg.sv]
package kli_pkg;
  // ----------------------------------------
  // Register map and field layout
  // ----------------------------------------
  localparam int KLI_LINES = 8;
  localparam logic [7:0] KLI_ADDR_LEVEL = 8'h9C;
  localparam logic [7:0] KLI_ADDR_ENABLE = 8'h9D;
  localparam logic [7:0] KLI_ADDR_FLAGS = 8'h9E;
  localparam logic [7:0] KLI_RESET_VALUE = 8'h00;
  localparam int KLI_SYNC_STAGES = 2;
endpackage

// [kli_top.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Keypad level interrupt controller
// ----------------------------------------
module kli_top
  import kli_pkg::*;
(
  input wire logic clock, // 20 MHz clock
  input wire logic reset_n, // Async reset, active low
  input wire logic [7:0] keypad_input_port, // Port lines in
  input wire logic [7:0] sfr_addr, // Register address
  input wire logic sfr_wr, // Write strobe
  input wire logic sfr_rd, // Read strobe
  input wire logic [7:0] sfr_wdata, // Write data
  input wire logic keypad_global_irq_enable, // Global enable bit
  input wire logic idle_set, // Core sets idle bit
  input wire logic irq_ack, // Core took an interrupt
  output logic [7:0] sfr_rdata, // Read data, registered
  output logic sfr_hit, // Address hit, registered
  output logic key_irq, // Combined request
  output logic wake_req, // Wake from idle or power-down
  output logic idle_request_bit, // Idle mode bit
  output logic [7:0] key_line_enable_alias // Lines owned by keypad
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] sync1_r, sync2_r;
  logic [7:0] key_level_select_r, key_level_select_nxt;
  logic [7:0] key_line_enable_r, key_line_enable_nxt;
  logic [7:0] key_line_flags_r, key_line_flags_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic hit_r, hit_nxt, irq_r, irq_nxt, wake_r, wake_nxt, idle_r, idle_nxt;
  logic [7:0] en_out_r;
  logic req_now;
  logic [1:0] warm_r, warm_nxt;
  logic [7:0] det_hit;

  kli_det_if det_if ();

  // Address decode used by read and write paths
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ref_a);
    return a == ref_a;
  endfunction

  // Two-stage input synchroniser
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= KLI_RESET_VALUE;
      sync2_r <= KLI_RESET_VALUE;
    end else begin
      sync1_r <= keypad_input_port;
      sync2_r <= sync1_r;
    end
  end

  assign det_if.line_sync = sync2_r;
  assign det_if.level_sel = key_level_select_r;

  // ----------------------------------------
  // Synchroniser warm-up
  // ----------------------------------------
  // Shift in ones until both sync stages hold pin samples
  always_comb begin
    warm_nxt = {warm_r[0], 1'b1};
  end

  // Warm-up register, cleared by reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      warm_r <= 2'b00;
    end else begin
      warm_r <= warm_nxt;
    end
  end

  // Reset contents of the sync flops would look like a low level on every line
  assign det_hit = det_if.hit & {KLI_LINES{warm_r[1]}};

  kli_detect u_detect (
    .det(det_if)
  );

  // Combined request from latched flags
  assign req_now = keypad_global_irq_enable &
    (|(key_line_flags_r & key_line_enable_r));

  // Next register, flag and output values
  always_comb begin
    key_level_select_nxt = key_level_select_r;
    key_line_enable_nxt = key_line_enable_r;
    key_line_flags_nxt = key_line_flags_r;
    rdata_nxt = 8'h00;
    hit_nxt = 1'b0;
    if (sfr_wr && is_reg(sfr_addr, KLI_ADDR_LEVEL))
      key_level_select_nxt = sfr_wdata;
    if (sfr_wr && is_reg(sfr_addr, KLI_ADDR_ENABLE))
      key_line_enable_nxt = sfr_wdata;
    if (sfr_rd) begin
      if (is_reg(sfr_addr, KLI_ADDR_LEVEL)) begin
        rdata_nxt = key_level_select_r;
        hit_nxt = 1'b1;
      end else if (is_reg(sfr_addr, KLI_ADDR_ENABLE)) begin
        rdata_nxt = key_line_enable_r;
        hit_nxt = 1'b1;
      end else if (is_reg(sfr_addr, KLI_ADDR_FLAGS)) begin
        rdata_nxt = key_line_flags_r;
        hit_nxt = 1'b1;
        key_line_flags_nxt = 8'h00;
      end
    end
    // New detection sets, winning over a clearing read
    key_line_flags_nxt = key_line_flags_nxt | det_hit;
    irq_nxt = req_now;
    wake_nxt = req_now;
    idle_nxt = idle_r;
    if (idle_set)
      idle_nxt = 1'b1;
    if (irq_ack || req_now)
      idle_nxt = 1'b0;
  end

  // Register stage
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      key_level_select_r <= KLI_RESET_VALUE;
      key_line_enable_r <= KLI_RESET_VALUE;
      key_line_flags_r <= KLI_RESET_VALUE;
      rdata_r <= 8'h00;
      hit_r <= 1'b0;
      irq_r <= 1'b0;
      wake_r <= 1'b0;
      idle_r <= 1'b0;
      en_out_r <= 8'h00;
    end else begin
      key_level_select_r <= key_level_select_nxt;
      key_line_enable_r <= key_line_enable_nxt;
      key_line_flags_r <= key_line_flags_nxt;
      rdata_r <= rdata_nxt;
      hit_r <= hit_nxt;
      irq_r <= irq_nxt;
      wake_r <= wake_nxt;
      idle_r <= idle_nxt;
      en_out_r <= key_line_enable_nxt;
    end
  end

  assign sfr_rdata = rdata_r;
  assign sfr_hit = hit_r;
  assign key_irq = irq_r;
  assign wake_req = wake_r;
  assign idle_request_bit = idle_r;
  assign key_line_enable_alias = en_out_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  flag_read_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
    (sfr_rd && sfr_addr == KLI_ADDR_FLAGS && det_hit == 8'h00)
      |=> key_line_flags_r == 8'h00)
    else $error("flag read did not clear flags");
  flag_set_wins_a: assert property (@(posedge clock) disable iff (!reset_n)
    ((det_hit & 8'h01) != 8'h00) |=> key_line_flags_r[0])
    else $error("detection lost on flag 0");
  irq_combine_a: assert property (@(posedge clock) disable iff (!reset_n)
    key_irq == $past(req_now))
    else $error("request mismatch");
  irq_global_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
    !keypad_global_irq_enable |=> !key_irq)
    else $error("request without global enable");
  irq_masked_a: assert property (@(posedge clock) disable iff (!reset_n)
    (key_line_enable_r == 8'h00) |=> !key_irq)
    else $error("request with all lines disabled");
  level_low_a: assert property (@(posedge clock) disable iff (!reset_n)
    (warm_r[1] && !key_level_select_r[0] && !sync2_r[0]) |=> key_line_flags_r[0])
    else $error("low level not flagged");
  level_high_a: assert property (@(posedge clock) disable iff (!reset_n)
    (warm_r[1] && key_level_select_r[1] && sync2_r[1]) |=> key_line_flags_r[1])
    else $error("high level not flagged");
  idle_exit_a: assert property (@(posedge clock) disable iff (!reset_n)
    req_now |=> !idle_request_bit)
    else $error("idle not cleared by request");
  wake_follow_a: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(key_irq) |-> wake_req)
    else $error("wake missing");

  // ----------------------------------------
  // Synchroniser and register checks
  // ----------------------------------------
  // Second stage follows the first
  sync_pipe_a: assert property (@(posedge clock) disable iff (!reset_n)
    sync2_r == $past(sync1_r))
    else $error("sync stage skipped");
  // Level select write lands next cycle
  level_write_a: assert property (@(posedge clock) disable iff (!reset_n)
    (sfr_wr && sfr_addr == KLI_ADDR_LEVEL) |=> key_level_select_r == $past(sfr_wdata))
    else $error("level select write lost");
  // Enable write lands next cycle
  enable_write_a: assert property (@(posedge clock) disable iff (!reset_n)
    (sfr_wr && sfr_addr == KLI_ADDR_ENABLE) |=> key_line_enable_r == $past(sfr_wdata))
    else $error("enable write lost");
  // Pin ownership copy follows enable writes
  alias_write_a: assert property (@(posedge clock) disable iff (!reset_n)
    (sfr_wr && sfr_addr == KLI_ADDR_ENABLE) |=> key_line_enable_alias == $past(sfr_wdata))
    else $error("pin owner copy lost");
  // Flag register ignores writes
  flags_ro_a: assert property (@(posedge clock) disable iff (!reset_n)
    (sfr_wr && !sfr_rd && sfr_addr == KLI_ADDR_FLAGS)
      |=> key_line_flags_r == ($past(key_line_flags_r) | $past(det_hit)))
    else $error("flag register written");
  // Flags only accumulate between reads
  flags_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    !(sfr_rd && sfr_addr == KLI_ADDR_FLAGS)
      |=> key_line_flags_r == ($past(key_line_flags_r) | $past(det_hit)))
    else $error("flag changed without read");
  // A read leaves only fresh detections
  flags_after_rd_a: assert property (@(posedge clock) disable iff (!reset_n)
    (sfr_rd && sfr_addr == KLI_ADDR_FLAGS) |=> key_line_flags_r == $past(det_hit))
    else $error("flags after read wrong");

  // ----------------------------------------
  // Read path checks
  // ----------------------------------------
  // Level select read back
  read_level_a: assert property (@(posedge clock) disable iff (!reset_n)
    (sfr_rd && sfr_addr == KLI_ADDR_LEVEL)
      |=> (sfr_hit && sfr_rdata == $past(key_level_select_r)))
    else $error("level select read wrong");
  // Enable read back
  read_enable_a: assert property (@(posedge clock) disable iff (!reset_n)
    (sfr_rd && sfr_addr == KLI_ADDR_ENABLE)
      |=> (sfr_hit && sfr_rdata == $past(key_line_enable_r)))
    else $error("enable read wrong");
  // Flag read returns flags before clearing
  read_flags_a: assert property (@(posedge clock) disable iff (!reset_n)
    (sfr_rd && sfr_addr == KLI_ADDR_FLAGS)
      |=> (sfr_hit && sfr_rdata == $past(key_line_flags_r)))
    else $error("flag read wrong");
  // Bus quiet without a read
  read_quiet_a: assert property (@(posedge clock) disable iff (!reset_n)
    !sfr_rd |=> (!sfr_hit && sfr_rdata == 8'h00))
    else $error("read data without read");
  // Unmapped reads give nothing
  read_unmapped_a: assert property (@(posedge clock) disable iff (!reset_n)
    (sfr_rd && sfr_addr != KLI_ADDR_LEVEL && sfr_addr != KLI_ADDR_ENABLE
      && sfr_addr != KLI_ADDR_FLAGS) |=> (!sfr_hit && sfr_rdata == 8'h00))
    else $error("unmapped read answered");

  // ----------------------------------------
  // Request and idle checks
  // ----------------------------------------
  // No request without an enabled flag
  irq_no_flag_a: assert property (@(posedge clock) disable iff (!reset_n)
    ((key_line_flags_r & key_line_enable_r) == 8'h00) |=> !key_irq)
    else $error("request without enabled flag");
  // Any enabled flag raises the shared request while the global enable is set
  irq_any_line_a: assert property (@(posedge clock) disable iff (!reset_n)
    (keypad_global_irq_enable && (key_line_flags_r & key_line_enable_r) != 8'h00)
      |=> key_irq)
    else $error("enabled flag gave no request");
  // Wake follows the request
  wake_req_a: assert property (@(posedge clock) disable iff (!reset_n)
    req_now |=> wake_req)
    else $error("wake not raised");
  // Core sets the idle bit
  idle_set_a: assert property (@(posedge clock) disable iff (!reset_n)
    (idle_set && !irq_ack && !req_now) |=> idle_request_bit)
    else $error("idle bit not set");
  // Idle bit holds without cause
  idle_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    (!idle_set && !irq_ack && !req_now) |=> idle_request_bit == $past(idle_request_bit))
    else $error("idle bit moved");
  // Any taken interrupt ends idle
  idle_ack_a: assert property (@(posedge clock) disable iff (!reset_n)
    irq_ack |=> !idle_request_bit)
    else $error("idle not cleared by ack");

  // ----------------------------------------
  // Per-line checks
  // ----------------------------------------
  genvar k;
  // Each line flags its programmed level and never sets on its own
  generate
    for (k = 0; k < KLI_LINES; k++) begin : g_chk
      line_match_a: assert property (@(posedge clock) disable iff (!reset_n)
        (warm_r[1] && sync2_r[k] == key_level_select_r[k]) |=> key_line_flags_r[k])
        else $error("line level not flagged");
      line_quiet_a: assert property (@(posedge clock) disable iff (!reset_n)
        (!det_hit[k] && !key_line_flags_r[k]) |=> !key_line_flags_r[k])
        else $error("flag set without level");
    end
  endgenerate
endmodule

// [kli_top_tb.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Keypad level interrupt bench
// ----------------------------------------
module kli_top_tb;
  import kli_pkg::*;
  logic clock = 0, reset_n = 0, wr = 0, rd = 0, gie = 0, idle_set = 0, ack = 0, hit, hq;
  logic irq, wake, idle;
  logic [7:0] addr = 0, wdata = 0, press = 8'hFF, pins, rdata, al, q;
  int failures = 0, cmp_count = 0, seed = 44677, sel, en, m, exp;
  // 50 ns clock
  always #25 clock = ~clock;
  kli_keypad_model pad_u (.clock(clock), .press(press), .lines(pins));
  kli_top dut_u (.clock(clock), .reset_n(reset_n), .keypad_input_port(pins),
    .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdata),
    .keypad_global_irq_enable(gie), .idle_set(idle_set), .irq_ack(ack),
    .sfr_rdata(rdata), .sfr_hit(hit), .key_irq(irq), .wake_req(wake),
    .idle_request_bit(idle), .key_line_enable_alias(al));
  // Compare one 8-bit result
  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask
  // Wait edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  // One register cycle; read data caught the cycle after
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    tick(1);
    q = rdata;
    hq = hit;
    wr = 0;
    rd = 0;
    tick(1);
  endtask
  // Verdict and end of run
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000;
    failures++;
    end_sim;
  end
  // Main sequence
  initial begin
    tick(16);
    reset_n = 1;
    tick(1);
    for (int i = 0; i < 3; i++) begin
      acc(0, 8'(KLI_ADDR_LEVEL + i), 8'h00);
      chk("reset value", KLI_RESET_VALUE, q);
    end
    $display("test reset done");
    repeat (12) begin
      sel = $random(seed) & 255;
      en = $random(seed) & 255;
      m = $random(seed) & 255;
      gie = 1'($random(seed));
      press = 8'(~sel);
      tick(4);
      acc(1, KLI_ADDR_LEVEL, 8'(sel));
      acc(1, KLI_ADDR_ENABLE, 8'(en));
      acc(0, KLI_ADDR_FLAGS, 8'h00);
      acc(1, KLI_ADDR_FLAGS, 8'hFF);
      acc(0, KLI_ADDR_FLAGS, 8'h00);
      chk("cleared flags", 8'h00, q);
      press = 8'(sel ^ m);
      exp = ~m & 255;
      tick(5);
      chk("request", {7'h0, gie && (exp & en) != 0}, {7'h0, irq});
      chk("wake", {7'h0, gie && (exp & en) != 0}, {7'h0, wake});
      chk("pin owner", 8'(en), al);
      acc(0, KLI_ADDR_FLAGS, 8'h00);
      chk("flags", 8'(exp), q);
      chk("flag hit", 8'h01, {7'h0, hq});
    end
    $display("test levels done");
    acc(0, 8'h9B, 8'h00);
    chk("unmapped hit", 8'h00, {7'h0, hq});
    chk("unmapped data", 8'h00, q);
    press = 8'hFF;
    tick(4);
    reset_n = 0;
    tick(2);
    reset_n = 1;
    tick(1);
    chk("irq after reset", 8'h00, {7'h0, irq});
    chk("owner after reset", 8'h00, al);
    for (int i = 0; i < 3; i++) begin
      acc(0, 8'(KLI_ADDR_LEVEL + i), 8'h00);
      chk("reset again", KLI_RESET_VALUE, q);
    end
    $display("test mid reset done");
    gie = 0;
    acc(1, KLI_ADDR_ENABLE, 8'hFF);
    press = 8'h00;
    idle_set = 1;
    tick(1);
    idle_set = 0;
    tick(5);
    chk("idle held", 8'h01, {7'h0, idle});
    chk("gated request", 8'h00, {7'h0, irq});
    gie = 1;
    tick(2);
    chk("wake request", 8'h01, {7'h0, wake});
    chk("idle woken", 8'h00, {7'h0, idle});
    $display("test wake done");
    gie = 0;
    idle_set = 1;
    tick(2);
    idle_set = 0;
    chk("idle set", 8'h01, {7'h0, idle});
    ack = 1;
    tick(2);
    ack = 0;
    chk("idle clear", 8'h00, {7'h0, idle});
    $display("test idle done");
    end_sim;
  end
endmodule
